// >>> hw/cpcs_pkg.sv
// package for the camera port configuration and status block
// assumes a word-indexed register port: byte address is four times the register index
package cpcs_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;
    // register indices, byte address = index * 4
    localparam logic [IDX_W-1:0] IDX_CHIP_ID = 14'h0000;
    localparam logic [IDX_W-1:0] IDX_MEM_SEL = 14'h0001;
    localparam logic [IDX_W-1:0] IDX_GPIO_CFG = 14'h0004;
    localparam logic [IDX_W-1:0] IDX_GPIO_STAT = 14'h0008;
    localparam logic [IDX_W-1:0] IDX_STRAP_RB = 14'h000d;
    localparam logic [IDX_W-1:0] IDX_PCLK_SEL = 14'h001c;
    localparam logic [IDX_W-1:0] IDX_CAM_CMD = 14'h1000;
    localparam logic [IDX_W-1:0] IDX_INT_STAT = 14'h1002;
    localparam logic [IDX_W-1:0] IDX_INT_MASK = 14'h1003;
    // field positions
    localparam int MEM_SEL_BIT = 7;
    localparam int SHARED_GPIO_PIN_BIT = 2;
    localparam int STRAP_A_BIT = 5;
    localparam int STRAP_B_BIT = 6;
    localparam logic [7:0] STRAP_MASK = 8'h60;
    localparam int CMD_PWR_BIT = 1;
    localparam int CMD_CABLE_BIT = 7;
    localparam int CMD_REV_LSB = 8;
    localparam logic [15:0] CMD_REV_MASK = 16'h0f00;
    localparam int PCLK_SRC_BIT = 0;
    localparam int PCLK_DIV_LSB = 1;
    localparam int PCLK_DIV_W = 4;
    localparam int INT_W = 2;
    localparam int INT_ATTACH = 0;
    localparam int INT_DETACH = 1;
    // reset values
    localparam logic [7:0] MEM_SEL_RST = 8'h80;
    localparam logic [7:0] GPIO_CFG_RST = 8'h00;
    localparam logic [7:0] GPIO_STAT_RST = 8'h00;
    localparam logic [7:0] PCLK_SEL_RST = 8'h00;
    localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;
    // synchroniser bits and settle time before the straps are caught
    localparam int SYNC_W = 5;
    localparam int SY_STRAP_A = 0;
    localparam int SY_STRAP_B = 1;
    localparam int SY_CABLE_N = 2;
    localparam int SY_AUX = 3;
    localparam int SY_GPIO = 4;
    localparam logic [2:0] STRAP_SETTLE = 3'h4;
    typedef enum {ST_SETTLE, ST_HOLD} cpcs_strap_state_type;
endpackage

// >>> hw/cpcs_pclk_if.sv
// interface between the register bank and the camera port clock generator
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface cpcs_pclk_if;
    logic enable;
    logic src_sys;
    logic [3:0] div;
    logic aux_rise;
    logic port_clk;
    modport ctrl (output enable, output src_sys, output div, output aux_rise, input port_clk);
    modport gen (input enable, input src_sys, input div, input aux_rise, output port_clk);
endinterface

// >>> hw/cpcs_sync.sv
// three-stage pin synchroniser; the output moves once stages two and three agree
// assumes asynchronous pin inputs and the single system clock
`timescale 1ns/1ps
module cpcs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    out_q <= 1'b0;
                end
                else
                begin
                    s1_q <= i_async[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                    begin
                        out_q <= s3_q;
                    end
                end
            end
            assign o_sync[gi] = out_q;
        end
    endgenerate
endmodule

// >>> hw/cpcs_pclk_gen.sv
// camera port clock generator: divides the chosen source events
// assumes source events arrive as one-cycle pulses on the system clock
`timescale 1ns/1ps
module cpcs_pclk_gen (
    input wire logic i_clk,
    input wire logic i_reset,
    cpcs_pclk_if.gen pif
);
    logic [3:0] cnt_q;
    logic clk_q;
    logic src_evt;
    assign src_evt = pif.src_sys | pif.aux_rise;
    // port clock toggles every div+1 source events
    always_ff @(posedge i_clk)
    begin
        if (i_reset || !pif.enable)
        begin
            cnt_q <= 4'h0;
            clk_q <= 1'b0;
        end
        else if (src_evt)
        begin
            // a divider lowered mid-count restarts at once instead of wrapping
            if (cnt_q >= pif.div)
            begin
                cnt_q <= 4'h0;
                clk_q <= ~clk_q; // [RL10]
            end
            else
            begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
    assign pif.port_clk = clk_q;
    chk_pclk_hold: assert property (@(posedge i_clk) disable iff (i_reset) // [RL10]
        (pif.enable && !src_evt) ##1 pif.enable |-> $stable(clk_q))
        else $error("port clock moved without a source event");
endmodule

// >>> hw/cpcs_top.sv
// camera port configuration and status register bank with chip identification
// assumes a one-cycle strobe register port, read data valid the cycle after the read
//
// Contract
// [RL1] port is enabled only when both camera straps read high at reset
// [RL2] while enabled the shared gpio pin follows the camera command register
// [RL3] while enabled the camera power signal drives the shared address/gpio pin
// [RL4] a 16-bit camera command register sits at index 1000h
// [RL5] command bits 11 to 8 carry the interface revision, masked by 0F00h
// [RL6] command bit 7 reads 0 with a camera attached, 1 without
// [RL7] command bit 1 sets remote camera power and drives the shared pin
// [RL8] readback at 00Dh returns the latched straps; mask 60h shows enable
// [RL9] while enabled panel data bits 15 to 8 belong to the camera port
// [RL10] clock register at 01Ch picks source and divider; software keeps 8 to 19 MHz
// [RL11] identification reads only with the select bit clear, written 00h at 001h
// [RL12] identification holds fixed product code bits 7-2 and revision bits 1-0
// [RL13] strap values are caught once after reset and held until next reset
`timescale 1ns/1ps
module cpcs_top
    import cpcs_pkg::*;
#(
    parameter logic [5:0] CHIP_PRODUCT = 6'h2a, // arbitrary value
    parameter logic [1:0] CHIP_REV = 2'h2, // arbitrary value
    parameter logic [3:0] IFACE_REV = 4'h5 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_irq,
    input wire logic i_strap_cam_a,
    input wire logic i_strap_cam_b,
    input wire logic i_cam_cable_n,
    input wire logic i_aux_clock_input,
    input wire logic i_shared_gpio_in,
    output logic o_shared_gpio_out,
    output logic o_shared_gpio_oe,
    input wire logic [15:0] i_panel_data,
    input wire logic [7:0] i_cam_data,
    output logic [15:0] o_panel_data,
    output logic o_panel_upper_owned,
    output logic o_cam_port_clk,
    output logic o_cam_port_en
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
    endfunction

    logic [SYNC_W-1:0] pins_s;
    logic [7:0] mem_sel_q;
    logic [7:0] gpio_cfg_q;
    logic [7:0] gpio_stat_q;
    logic [7:0] pclk_sel_q;
    logic cmd_pwr_q;
    logic [INT_W-1:0] int_stat_q;
    logic [INT_W-1:0] int_mask_q;
    logic [1:0] strap_q;
    logic [2:0] settle_q;
    cpcs_strap_state_type strap_st_q;
    logic cable_prev_q;
    logic aux_prev_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q;
    logic gpio_out_q;
    logic gpio_oe_q;
    logic [15:0] panel_q;
    logic owned_q;
    logic pclk_q;
    logic pen_q;
    logic cam_en;
    logic cmd_wr;
    logic [15:0] cmd_rd;
    logic [INT_W-1:0] int_set;
    logic int_clr;

    cpcs_pclk_if pif ();

    cpcs_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_shared_gpio_in, i_aux_clock_input, i_cam_cable_n, i_strap_cam_b,
            i_strap_cam_a}),
        .o_sync(pins_s)
    );

    cpcs_pclk_gen u_pclk (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .pif(pif.gen)
    );

    assign cam_en = strap_q[0] & strap_q[1]; // [RL1]
    assign cmd_wr = i_we && reg_hit(i_addr, IDX_CAM_CMD);

    // straps are caught once the synchroniser has filled after reset
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            strap_st_q <= ST_SETTLE;
            settle_q <= 3'h0;
            strap_q <= 2'h0;
        end
        else
        begin
            case (strap_st_q)
                ST_SETTLE:
                begin
                    settle_q <= settle_q + 3'h1;
                    if (settle_q == STRAP_SETTLE)
                    begin
                        strap_q <= {pins_s[SY_STRAP_B], pins_s[SY_STRAP_A]}; // [RL13]
                        strap_st_q <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    strap_q <= strap_q; // [RL13]
                end
                default:
                begin
                    strap_st_q <= ST_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            mem_sel_q <= MEM_SEL_RST;
        end
        else if (i_we && reg_hit(i_addr, IDX_MEM_SEL))
        begin
            mem_sel_q <= i_wdata[7:0]; // [RL11]
        end
    end

    // gpio registers keep their values but lose the pin while the port is enabled
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            gpio_cfg_q <= GPIO_CFG_RST;
            gpio_stat_q <= GPIO_STAT_RST;
        end
        else
        begin
            if (i_we && reg_hit(i_addr, IDX_GPIO_CFG))
            begin
                gpio_cfg_q <= i_wdata[7:0];
            end
            if (i_we && reg_hit(i_addr, IDX_GPIO_STAT))
            begin
                gpio_stat_q <= i_wdata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            pclk_sel_q <= PCLK_SEL_RST;
        end
        else if (i_we && reg_hit(i_addr, IDX_PCLK_SEL))
        begin
            pclk_sel_q <= i_wdata[7:0]; // [RL10]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cmd_pwr_q <= 1'b0;
        end
        else if (cmd_wr)
        begin
            cmd_pwr_q <= i_wdata[CMD_PWR_BIT]; // [RL7]
        end
    end

    // cable events: active-low cable line going low is an attach
    assign int_set[INT_ATTACH] = (strap_st_q == ST_HOLD) && cable_prev_q && !pins_s[SY_CABLE_N];
    assign int_set[INT_DETACH] = (strap_st_q == ST_HOLD) && !cable_prev_q && pins_s[SY_CABLE_N];
    assign int_clr = i_re && reg_hit(i_addr, IDX_INT_STAT);

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cable_prev_q <= 1'b0;
            aux_prev_q <= 1'b0;
        end
        else
        begin
            cable_prev_q <= pins_s[SY_CABLE_N];
            aux_prev_q <= pins_s[SY_AUX];
        end
    end

    // a new event in the clearing read's cycle stays set
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            int_stat_q <= '0;
            int_mask_q <= INT_MASK_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            int_stat_q <= (int_clr ? '0 : int_stat_q) | int_set;
            if (i_we && reg_hit(i_addr, IDX_INT_MASK))
            begin
                int_mask_q <= i_wdata[INT_W-1:0];
            end
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    always_comb
    begin
        cmd_rd = 16'h0000; // [RL4]
        cmd_rd[CMD_REV_LSB +: 4] = IFACE_REV; // [RL5]
        cmd_rd[CMD_CABLE_BIT] = pins_s[SY_CABLE_N]; // [RL6]
        cmd_rd[CMD_PWR_BIT] = cmd_pwr_q;
    end

    always_comb
    begin
        rdata_d = '0;
        if (i_re)
        begin
            if (reg_hit(i_addr, IDX_CHIP_ID) && !mem_sel_q[MEM_SEL_BIT])
            begin
                rdata_d[7:0] = {CHIP_PRODUCT, CHIP_REV}; // [RL11] [RL12]
            end
            else if (reg_hit(i_addr, IDX_MEM_SEL))
            begin
                rdata_d[7:0] = mem_sel_q;
            end
            else if (reg_hit(i_addr, IDX_GPIO_CFG))
            begin
                rdata_d[7:0] = gpio_cfg_q;
            end
            else if (reg_hit(i_addr, IDX_GPIO_STAT))
            begin
                rdata_d[7:0] = gpio_stat_q;
                rdata_d[SHARED_GPIO_PIN_BIT] = pins_s[SY_GPIO];
            end
            else if (reg_hit(i_addr, IDX_STRAP_RB))
            begin
                rdata_d[STRAP_A_BIT] = strap_q[0]; // [RL8]
                rdata_d[STRAP_B_BIT] = strap_q[1]; // [RL8]
            end
            else if (reg_hit(i_addr, IDX_PCLK_SEL))
            begin
                rdata_d[7:0] = pclk_sel_q;
            end
            else if (reg_hit(i_addr, IDX_CAM_CMD))
            begin
                rdata_d[15:0] = cmd_rd;
            end
            else if (reg_hit(i_addr, IDX_INT_STAT))
            begin
                rdata_d[INT_W-1:0] = int_stat_q;
            end
            else if (reg_hit(i_addr, IDX_INT_MASK))
            begin
                rdata_d[INT_W-1:0] = int_mask_q;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // shared pin: camera power overrides the gpio bits while enabled
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            gpio_out_q <= 1'b0;
            gpio_oe_q <= 1'b0;
        end
        else if (cam_en)
        begin
            gpio_out_q <= cmd_pwr_q; // [RL2] [RL3] [RL7]
            gpio_oe_q <= 1'b1; // [RL3]
        end
        else
        begin
            gpio_out_q <= gpio_stat_q[SHARED_GPIO_PIN_BIT];
            gpio_oe_q <= gpio_cfg_q[SHARED_GPIO_PIN_BIT];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            panel_q <= 16'h0000;
            owned_q <= 1'b0;
        end
        else
        begin
            panel_q[7:0] <= i_panel_data[7:0];
            panel_q[15:8] <= cam_en ? i_cam_data : i_panel_data[15:8]; // [RL9]
            owned_q <= cam_en; // [RL9]
        end
    end

    assign pif.enable = cam_en;
    assign pif.src_sys = pclk_sel_q[PCLK_SRC_BIT]; // [RL10]
    assign pif.div = pclk_sel_q[PCLK_DIV_LSB +: PCLK_DIV_W];
    assign pif.aux_rise = pins_s[SY_AUX] & ~aux_prev_q;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            pclk_q <= 1'b0;
            pen_q <= 1'b0;
        end
        else
        begin
            pclk_q <= pif.port_clk;
            pen_q <= cam_en;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    assign o_shared_gpio_out = gpio_out_q;
    assign o_shared_gpio_oe = gpio_oe_q;
    assign o_panel_data = panel_q;
    assign o_panel_upper_owned = owned_q;
    assign o_cam_port_clk = pclk_q;
    assign o_cam_port_en = pen_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_cmd_read;
        i_re && reg_hit(i_addr, IDX_CAM_CMD);
    endsequence
    sequence s_pwr_write;
        cam_en && cmd_wr ##1 (cam_en && !cmd_wr) ##1 cam_en;
    endsequence

    chk_strap_hold: assert property ((strap_st_q == ST_HOLD) |=> $stable(strap_q)) // [RL13]
        else $error("latched straps changed after reset");
    chk_enable_both: assert property (o_cam_port_en == ($past(strap_q) == 2'h3)) // [RL1]
        else $error("port enabled without both straps");
    chk_gpio_follow: assert property (s_pwr_write |-> // [RL2] [RL7]
        o_shared_gpio_out == $past(i_wdata[CMD_PWR_BIT], 2))
        else $error("shared pin does not follow power bit");
    chk_power_drive: assert property (cam_en [*2] |-> o_shared_gpio_oe) // [RL3]
        else $error("shared pin not driven while enabled");
    chk_cmd_upper: assert property (s_cmd_read |=> o_rdata[31:16] == 16'h0000) // [RL4]
        else $error("command read carries bits above 16");
    chk_rev_field: assert property (s_cmd_read |=> // [RL5]
        (o_rdata[15:0] & CMD_REV_MASK) == {4'h0, IFACE_REV, 8'h00})
        else $error("revision field wrong");
    chk_cable_bit: assert property (s_cmd_read |=> // [RL6]
        o_rdata[CMD_CABLE_BIT] == $past(pins_s[SY_CABLE_N]))
        else $error("cable bit does not match pin");
    chk_strap_readback: assert property (i_re && reg_hit(i_addr, IDX_STRAP_RB) |=> // [RL8]
        ((o_rdata[7:0] & STRAP_MASK) == STRAP_MASK) == $past(cam_en))
        else $error("strap readback disagrees with enable");
    chk_panel_upper: assert property (cam_en |=> // [RL9]
        o_panel_data[15:8] == $past(i_cam_data) && o_panel_upper_owned)
        else $error("panel upper lines not given to camera");
    chk_id_gate: assert property (i_re && reg_hit(i_addr, IDX_CHIP_ID) |=> // [RL11] [RL12]
        o_rdata[7:0] == ($past(mem_sel_q[MEM_SEL_BIT]) ? 8'h00 : {CHIP_PRODUCT, CHIP_REV}))
        else $error("identification read wrong");
    chk_irq_level: assert property (|(int_stat_q & int_mask_q) |=> o_irq)
        else $error("interrupt not raised");
endmodule

// >>> test/cpcs_cam_model.sv
// camera on the far side of the port: cable sense, data lines and its source clock
// assumes power comes from the shared pin and attach is commanded by the bench
`timescale 1ns/1ps
module cpcs_cam_model (
    input wire logic i_clk,
    input wire logic i_attach,
    input wire logic i_power,
    output logic o_cable_n,
    output logic [7:0] o_cam_data,
    output logic o_aux_clk
);
    logic [7:0] aux_cnt_q = 8'h00;
    logic [7:0] idle_q = 8'h00;
    // cable sense reads low while a camera is plugged in
    assign o_cable_n = ~i_attach;
    always @(posedge i_clk)
    begin
        aux_cnt_q <= aux_cnt_q + 8'h01;
        idle_q <= idle_q + 8'h3b;
    end
    // one eighth of the system clock: 25 MHz source, 12.5 MHz port clock at divider 0
    assign o_aux_clk = aux_cnt_q[2];
    // unpowered lines float, shown as a pattern that changes every cycle
    assign o_cam_data = i_power ? 8'h5a : ~idle_q;
endmodule

// >>> test/tb.sv
// self-checking bench for the camera port register bank
// assumes the camera model file is compiled before it
`timescale 1ns/1ps
module tb;
    import cpcs_pkg::*;
    localparam logic [5:0] PRODUCT = 6'h2a; // arbitrary value
    localparam logic [1:0] REV = 2'h2; // arbitrary value
    localparam logic [3:0] IREV = 4'h5; // arbitrary value
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_we = 1'b0;
    logic i_re = 1'b0;
    logic i_strap_cam_a = 1'b1;
    logic i_strap_cam_b = 1'b1;
    logic [15:0] i_panel_data = 16'h1234;
    logic attach = 1'b1;
    logic cable_n;
    logic aux_clk;
    logic [7:0] cam_data;
    logic [DATA_W-1:0] o_rdata;
    logic o_irq;
    logic o_shared_gpio_out;
    logic o_shared_gpio_oe;
    logic [15:0] o_panel_data;
    logic o_panel_upper_owned;
    logic o_cam_port_clk;
    logic o_cam_port_en;
    logic [DATA_W-1:0] rd;
    int num_errors = 0;
    int checks_done = 0;
    int cnt;
    // shared pin has a pull-up when nobody drives it
    wire pin_level = o_shared_gpio_oe ? o_shared_gpio_out : 1'b1;

    always #2.5 i_clk = ~i_clk;

    cpcs_top #(.CHIP_PRODUCT(PRODUCT), .CHIP_REV(REV), .IFACE_REV(IREV)) dut_u (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .o_irq(o_irq),
        .i_strap_cam_a(i_strap_cam_a), .i_strap_cam_b(i_strap_cam_b),
        .i_cam_cable_n(cable_n), .i_aux_clock_input(aux_clk),
        .i_shared_gpio_in(pin_level), .o_shared_gpio_out(o_shared_gpio_out),
        .o_shared_gpio_oe(o_shared_gpio_oe), .i_panel_data(i_panel_data),
        .i_cam_data(cam_data), .o_panel_data(o_panel_data),
        .o_panel_upper_owned(o_panel_upper_owned), .o_cam_port_clk(o_cam_port_clk),
        .o_cam_port_en(o_cam_port_en)
    );

    cpcs_cam_model cam_u (
        .i_clk(i_clk), .i_attach(attach), .i_power(pin_level),
        .o_cable_n(cable_n), .o_cam_data(cam_data), .o_aux_clk(aux_clk)
    );

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_we <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_re <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // counts rising edges of the port clock over n system cycles
    task automatic count_rise(input int n, output int c);
        logic prev;
        c = 0;
        prev = o_cam_port_clk;
        repeat (n)
        begin
            @(posedge i_clk);
            #1;
            if (o_cam_port_clk && !prev)
                c++;
            prev = o_cam_port_clk;
        end
    endtask

    task automatic do_reset;
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        wait_cyc(10);
    endtask

    initial
    begin
        repeat (5000) @(posedge i_clk);
        num_errors++;
        end_sim();
    end

    initial
    begin
        do_reset();
        check(o_cam_port_en, 1);
        rd_reg(16'h0034, rd);
        check(rd & 32'h60, 32'h60);
        i_strap_cam_a <= 1'b0;
        i_strap_cam_b <= 1'b0;
        wait_cyc(10);
        rd_reg(16'h0034, rd);
        check(rd & 32'h60, 32'h60);
        check(o_cam_port_en, 1);
        // identification hidden until the select bit is cleared
        rd_reg(16'h0000, rd);
        check(rd, 0);
        wr(16'h0004, 32'h0);
        rd_reg(16'h0004, rd);
        check(rd, 0);
        rd_reg(16'h0000, rd);
        check(rd, {24'h0, PRODUCT, REV});
        wr(16'h0000, 32'hff);
        rd_reg(16'h0000, rd);
        check(rd, {24'h0, PRODUCT, REV});
        wait_cyc(1);
        check(o_rdata, 0);
        rd_reg(16'h0002, rd);
        check(rd, 0);
        rd_reg(16'h0100, rd);
        check(rd, 0);
        // revision field and cable sense, camera attached
        rd_reg(16'h4000, rd);
        check(rd & 32'h0f00, {20'h0, IREV, 8'h0});
        check(rd & 32'hffff_f07d, 0);
        check(rd & 32'h80, 0);
        // detach raises the unmasked event, read clears it
        rd_reg(16'h4008, rd);
        wr(16'h400c, 32'h3);
        attach <= 1'b0;
        wait_cyc(10);
        check(o_irq, 1);
        rd_reg(16'h4000, rd);
        check(rd & 32'h80, 32'h80);
        rd_reg(16'h4008, rd);
        check(rd, 32'h2);
        wait_cyc(2);
        check(o_irq, 0);
        wr(16'h400c, 32'h2);
        attach <= 1'b1;
        wait_cyc(10);
        check(o_irq, 0);
        rd_reg(16'h4008, rd);
        check(rd, 32'h1);
        rd_reg(16'h4008, rd);
        check(rd, 0);
        // gpio registers ask for low, power bit wins
        wr(16'h0010, 32'h4);
        wr(16'h0020, 32'h0);
        wr(16'h4000, 32'h2);
        wait_cyc(3);
        check(o_shared_gpio_out, 1);
        check(o_shared_gpio_oe, 1);
        rd_reg(16'h4000, rd);
        check(rd & 32'h2, 32'h2);
        wr(16'h0020, 32'h4);
        wr(16'h4000, 32'h0);
        wait_cyc(3);
        check(o_shared_gpio_out, 0);
        check(o_shared_gpio_oe, 1);
        // camera powered, upper panel byte carries its data
        wr(16'h4000, 32'h2);
        wait_cyc(4);
        check(o_panel_data, 16'h5a34);
        check(o_panel_upper_owned, 1);
        // system clock source, divider 6: toggle every 7 cycles, about 14 MHz
        wr(16'h0070, 32'h0d);
        rd_reg(16'h0070, rd);
        check(rd, 32'h0d);
        wait_cyc(16);
        count_rise(140, cnt);
        check(cnt, 10);
        // auxiliary source, divider 0: toggle on every rising source edge
        wr(16'h0070, 32'h0);
        wait_cyc(40);
        count_rise(160, cnt);
        check(cnt, 10);
        // second reset with one strap low leaves the port off
        i_strap_cam_a <= 1'b1;
        i_strap_cam_b <= 1'b0;
        do_reset();
        check(o_cam_port_en, 0);
        rd_reg(16'h0034, rd);
        check(rd & 32'h60, 32'h20);
        check(o_panel_upper_owned, 0);
        check(o_panel_data, 16'h1234);
        check(o_cam_port_clk, 0);
        wr(16'h0010, 32'h4);
        wr(16'h0020, 32'h4);
        wait_cyc(3);
        check({o_shared_gpio_oe, o_shared_gpio_out}, 2'h3);
        wr(16'h0020, 32'h0);
        wait_cyc(3);
        check(o_shared_gpio_out, 0);
        // driven low pin reads back through the synchroniser
        wait_cyc(6);
        rd_reg(16'h0020, rd);
        check(rd & 32'h4, 0);
        end_sim();
    end
endmodule
